// file: logic/tcm_pkg.sv
// Contract
// - Trigger select 000 starts on software trigger only; undefined codes prohibited.
// - Trigger select 001 uses input valid edge as start and capture trigger.
// - Trigger select 010 uses one input edge to start, other to capture.
// - Trigger select 100 takes the master channel interrupt as trigger.
// - Edge select 0 means falling edge valid, 1 means rising edge valid.
// - Edge select 2 starts on falling edge, captures on rising edge.
// - Edge select 3 starts on rising edge, captures on falling edge.
// - Mode 000x is interval timer mode, counting down.
// - Mode 010x is capture mode, counting up.
// - Mode 0110 is event counter mode, counting down.
// - Mode 100x is one-count mode, counting down.
// - Mode 1100 is capture and one-count mode, counting up; others prohibited.
// - Interval or capture: start option raises interrupt and toggles output at start.
// - One-count: start option makes retrigger valid with interrupt; else ignored.
// - Event and capture one-count: no start interrupt, no output change, no retrigger.
// - Interval interrupt period is compare value plus one count clocks.
// - Output enable zero: pin follows software output bit, counting leaves it.
// - Output enable one: software output writes ignored, timer drives output.
// - Count source bit selects operation clock or input valid edge.
// - Clock select 00,01,10,11 picks prescaled clock a, c, b, d.
package tcm_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          CNT_W        = 16;
  localparam logic [7:0]  OFF_MODE_CFG = 8'h00;
  localparam logic [7:0]  OFF_COMPARE  = 8'h04;
  localparam logic [7:0]  OFF_OUT_CTRL = 8'h08;
  localparam logic [7:0]  OFF_CONTROL  = 8'h0C;
  localparam logic [7:0]  OFF_STATUS   = 8'h10;
  localparam logic [7:0]  OFF_CAPTURE  = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int          CLK_SEL_HI   = 15;
  localparam int          CLK_SEL_LO   = 14;
  localparam int          CNT_SRC_BIT  = 12;
  localparam int          TRIG_HI      = 10;
  localparam int          TRIG_LO      = 8;
  localparam int          EDGE_HI      = 7;
  localparam int          EDGE_LO      = 6;
  localparam int          MODE_HI      = 3;
  localparam int          MODE_LO      = 1;
  localparam int          OPT_BIT      = 0;
  localparam int          OE_BIT       = 0;
  localparam int          OUT_BIT      = 1;
  localparam int          SW_START_BIT = 0;
  localparam int          SW_STOP_BIT  = 1;
  localparam int          RUN_BIT      = 0;
  localparam logic [15:0] MODE_CFG_MASK = 16'hD7CF;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] MODE_CFG_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST  = 16'h0000;
  localparam logic        OE_RST       = 1'b0;
  localparam logic        OUT_RST      = 1'b0;
  localparam logic [2:0]  TRIG_SW      = 3'h0;
  localparam logic [2:0]  TRIG_EDGE    = 3'h1;
  localparam logic [2:0]  TRIG_BOTH    = 3'h2;
  localparam logic [2:0]  TRIG_MASTER  = 3'h4;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    TCM_INTERVAL, TCM_CAPTURE, TCM_EVENT, TCM_ONECOUNT, TCM_CAPONE, TCM_BAD
  } tcm_mode_t;

endpackage : tcm_pkg

// file: logic/tcm_pin_edge.sv
`timescale 1ns/1ns
module tcm_pin_edge (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin
  input  wire logic pin_async,
  // Edge pulses
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } tcm_edge_t;

  tcm_edge_t st_reg;
  tcm_edge_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = pin_async;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise = st_reg.sync2 & ~st_reg.prev;
  assign fall = ~st_reg.sync2 & st_reg.prev;

endmodule : tcm_pin_edge

// file: logic/tcm_channel.sv
`timescale 1ns/1ns
module tcm_channel #(
  parameter int CW = tcm_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write
  input  wire logic [tcm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [tcm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Prescaled clock enables and master trigger
  input  wire logic                     prescaled_clock_a,
  input  wire logic                     prescaled_clock_b,
  input  wire logic                     prescaled_clock_c,
  input  wire logic                     prescaled_clock_d,
  input  wire logic                     master_interrupt,
  // Pins and interrupt
  input  wire logic                     timer_input_pin,
  output logic                          timer_output_pin,
  output logic                          channel_interrupt
);
  import tcm_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic          w_have;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic [15:0]   mode_cfg;
    logic [CW-1:0] compare;
    logic          oe;
    logic          out_bit;
    logic [CW-1:0] counter;
    logic [CW-1:0] capture;
    logic          running;
    logic          irq;
  } tcm_state_t;

  tcm_state_t st_reg;
  tcm_state_t st_next;

  logic       pin_rise;
  logic       pin_fall;
  logic       valid_edge;
  logic       start_edge;
  logic       cap_edge;
  logic       op_clk;
  logic       tick;
  logic       sw_start;
  logic       sw_stop;
  logic       start_c;
  logic       capture_c;
  logic       wr_go;
  logic       wr_out;
  logic [2:0] trig;
  logic [1:0] edge_sel;
  logic       opt;
  tcm_mode_t  mode;

  tcm_pin_edge u_edge (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_async (timer_input_pin),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  // ----------------------------------------
  // Trigger and clock selection
  // ----------------------------------------
  always_comb begin
    trig     = st_reg.mode_cfg[TRIG_HI:TRIG_LO];
    edge_sel = st_reg.mode_cfg[EDGE_HI:EDGE_LO];
    opt      = st_reg.mode_cfg[OPT_BIT];
    unique case (st_reg.mode_cfg[MODE_HI:MODE_LO])
      3'b000: mode = TCM_INTERVAL;
      3'b010: mode = TCM_CAPTURE;
      3'b011: mode = opt ? TCM_BAD : TCM_EVENT;
      3'b100: mode = TCM_ONECOUNT;
      3'b110: mode = opt ? TCM_BAD : TCM_CAPONE;
      default: mode = TCM_BAD;
    endcase
    unique case (edge_sel)
      2'd0: begin
        valid_edge = pin_fall;
        start_edge = pin_fall;
        cap_edge   = pin_fall;
      end
      2'd1: begin
        valid_edge = pin_rise;
        start_edge = pin_rise;
        cap_edge   = pin_rise;
      end
      2'd2: begin
        valid_edge = pin_fall;
        start_edge = pin_fall;
        cap_edge   = pin_rise;
      end
      2'd3: begin
        valid_edge = pin_rise;
        start_edge = pin_rise;
        cap_edge   = pin_fall;
      end
    endcase
    unique case (st_reg.mode_cfg[CLK_SEL_HI:CLK_SEL_LO])
      2'b00: op_clk = prescaled_clock_a;
      2'b01: op_clk = prescaled_clock_c;
      2'b10: op_clk = prescaled_clock_b;
      2'b11: op_clk = prescaled_clock_d;
    endcase
    tick = st_reg.mode_cfg[CNT_SRC_BIT] ? valid_edge : op_clk;
  end

  // ----------------------------------------
  // Bus write decode
  // ----------------------------------------
  always_comb begin
    wr_go    = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    sw_start = wr_go && st_reg.aw_addr == OFF_CONTROL && st_reg.wstrb[0]
               && st_reg.wdata[SW_START_BIT];
    sw_stop  = wr_go && st_reg.aw_addr == OFF_CONTROL && st_reg.wstrb[0]
               && st_reg.wdata[SW_STOP_BIT];
    wr_out   = wr_go && st_reg.aw_addr == OFF_OUT_CTRL && st_reg.wstrb[0];
    unique case (trig)
      TRIG_EDGE: begin
        start_c   = sw_start || valid_edge;
        capture_c = valid_edge;
      end
      TRIG_BOTH: begin
        start_c   = sw_start || start_edge;
        capture_c = cap_edge;
      end
      TRIG_MASTER: begin
        start_c   = sw_start || master_interrupt;
        capture_c = 1'b0;
      end
      default: begin
        start_c   = sw_start;
        capture_c = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next     = st_reg;
    st_next.irq = 1'b0;
    // Write channel
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      unique case (st_reg.aw_addr)
        OFF_MODE_CFG: begin
          for (int b = 0; b < 2; b++) begin
            if (st_reg.wstrb[b]) begin
              st_next.mode_cfg[b*8 +: 8] = st_reg.wdata[b*8 +: 8] & MODE_CFG_MASK[b*8 +: 8];
            end
          end
        end
        OFF_COMPARE: begin
          for (int b = 0; b < CW/8; b++) begin
            if (st_reg.wstrb[b]) begin
              st_next.compare[b*8 +: 8] = st_reg.wdata[b*8 +: 8];
            end
          end
        end
        OFF_OUT_CTRL: begin
          if (st_reg.wstrb[0]) begin
            st_next.oe = st_reg.wdata[OE_BIT];
            if (!st_reg.oe) begin
              st_next.out_bit = st_reg.wdata[OUT_BIT];
            end
          end
        end
        OFF_CONTROL: begin
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_MODE_CFG: st_next.rdata[15:0] = st_reg.mode_cfg;
        OFF_COMPARE:  st_next.rdata[CW-1:0] = st_reg.compare;
        OFF_OUT_CTRL: st_next.rdata[1:0] = {st_reg.out_bit, st_reg.oe};
        OFF_CONTROL:  st_next.rdata = 32'h0000_0000;
        OFF_STATUS:   st_next.rdata = {st_reg.counter, 15'h0000, st_reg.running};
        OFF_CAPTURE:  st_next.rdata[CW-1:0] = st_reg.capture;
        default:      st_next.rresp = RESP_SLVERR;
      endcase
    end
    // Channel operation
    if (sw_stop) begin
      st_next.running = 1'b0;
    end else begin
      unique case (mode)
        TCM_INTERVAL, TCM_EVENT: begin
          if (start_c && !st_reg.running) begin
            st_next.running = 1'b1;
            st_next.counter = st_reg.compare;
            if (mode == TCM_INTERVAL && opt) begin
              st_next.irq = 1'b1;
              if (st_reg.oe) st_next.out_bit = ~st_reg.out_bit;
            end
          end else if (st_reg.running && tick) begin
            if (st_reg.counter == '0) begin
              st_next.counter = st_reg.compare;
              st_next.irq     = 1'b1;
              if (mode == TCM_INTERVAL && st_reg.oe) begin
                st_next.out_bit = ~st_reg.out_bit;
              end
            end else begin
              st_next.counter = st_reg.counter - 1'b1;
            end
          end
        end
        TCM_CAPTURE: begin
          if (start_c && !st_reg.running) begin
            st_next.running = 1'b1;
            st_next.counter = '0;
            if (opt) begin
              st_next.irq = 1'b1;
              if (st_reg.oe) st_next.out_bit = ~st_reg.out_bit;
            end
          end else if (st_reg.running && capture_c) begin
            st_next.capture = st_reg.counter;
            st_next.counter = '0;
            st_next.irq     = 1'b1;
          end else if (st_reg.running && tick) begin
            st_next.counter = st_reg.counter + 1'b1;
          end
        end
        TCM_ONECOUNT: begin
          if (start_c && (!st_reg.running || opt)) begin
            st_next.running = 1'b1;
            st_next.counter = st_reg.compare;
            st_next.irq     = st_reg.running;
            if (st_reg.oe) st_next.out_bit = 1'b1;
          end else if (st_reg.running && tick) begin
            if (st_reg.counter == '0) begin
              st_next.running = 1'b0;
              st_next.irq     = 1'b1;
              if (st_reg.oe) st_next.out_bit = 1'b0;
            end else begin
              st_next.counter = st_reg.counter - 1'b1;
            end
          end
        end
        TCM_CAPONE: begin
          if (start_c && !st_reg.running) begin
            st_next.running = 1'b1;
            st_next.counter = '0;
          end else if (st_reg.running && capture_c) begin
            st_next.capture = st_reg.counter;
            st_next.running = 1'b0;
            st_next.irq     = 1'b1;
          end else if (st_reg.running && tick) begin
            st_next.counter = st_reg.counter + 1'b1;
          end
        end
        TCM_BAD: st_next.running = 1'b0;
      endcase
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready  = !st_next.w_have && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= '0;
      st_reg.mode_cfg <= MODE_CFG_RST;
      st_reg.compare  <= CW'(COMPARE_RST);
      st_reg.oe       <= OE_RST;
      st_reg.out_bit  <= OUT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready     = st_reg.awready;
  assign s_axi_wready      = st_reg.wready;
  assign s_axi_bvalid      = st_reg.bvalid;
  assign s_axi_bresp       = st_reg.bresp;
  assign s_axi_arready     = st_reg.arready;
  assign s_axi_rvalid      = st_reg.rvalid;
  assign s_axi_rresp       = st_reg.rresp;
  assign s_axi_rdata       = st_reg.rdata;
  assign timer_output_pin  = st_reg.out_bit;
  assign channel_interrupt = st_reg.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_write_pair;
    st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
  endsequence

  sequence s_expiry;
    st_reg.running && mode == TCM_INTERVAL && tick && st_reg.counter == '0
      && !sw_stop;
  endsequence

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_pair |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write response missing");

  a_sw_only_start: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.running && trig == TRIG_SW && !sw_start |=> !st_reg.running)
    else $error("started without software trigger");

  a_interval_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    s_expiry |=> channel_interrupt && st_reg.counter == $past(st_reg.compare))
    else $error("interval expiry did not reload");

  a_interval_down: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.running && mode == TCM_INTERVAL && tick && st_reg.counter != '0
      && !sw_stop |=> st_reg.counter == $past(st_reg.counter) - 1'b1)
    else $error("interval counter not counting down");

  a_capture_up: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.running && mode == TCM_CAPTURE && tick && !capture_c && !sw_stop
      |=> st_reg.counter == $past(st_reg.counter) + 1'b1)
    else $error("capture counter not counting up");

  a_start_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.running && start_c && mode == TCM_INTERVAL && opt && !sw_stop
      |=> channel_interrupt && st_reg.running)
    else $error("start interrupt missing");

  a_event_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.running && start_c && mode == TCM_EVENT && !sw_stop
      |=> !channel_interrupt && $stable(st_reg.out_bit))
    else $error("event mode start changed output");

  a_retrig_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.running && mode == TCM_ONECOUNT && !opt && start_c && !tick
      && !sw_stop |=> $stable(st_reg.counter) && !channel_interrupt)
    else $error("one-count retrigger not ignored");

  a_out_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.oe && !wr_out |=> $stable(timer_output_pin))
    else $error("output moved while timer output disabled");

endmodule : tcm_channel

// file: test/tcm_pin_model.sv
`timescale 1ns/1ns
module tcm_pin_model (
  // Clock
  input  wire logic aclk,
  // Pins
  output logic      timer_input_pin,
  input  wire logic timer_output_pin
);
  logic seen_out;

  initial timer_input_pin = 1'b0;

  // Moves the input pin just after an edge; the level then holds until the next call
  task automatic drive(input logic lvl);
    @(posedge aclk);
    timer_input_pin <= lvl;
  endtask : drive

  always @(posedge aclk) begin
    seen_out <= timer_output_pin;
  end
endmodule : tcm_pin_model

// file: test/tb.sv
`timescale 1ns/1ns
module tb;
  import tcm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, arready;
  logic [1:0]  bresp, rresp;
  logic        bvalid, rvalid, pin_in, pin_out, irq;
  logic        pa = 0, pb = 0, pc = 0, pd = 0, mst = 0;
  logic        bready = 0, rready = 0;
  logic [3:0]  wstrb = 4'hF, strb = 4'hF;
  int          pcnt = 0, cycles = 0, num_errors = 0, compares = 0, irq_cnt = 0;
  int          div [4] = '{1, 3, 2, 4};

  always #2 aclk = ~aclk;

  // Regular enables of period 1, 2, 3 and 4 cycles
  always @(posedge aclk) begin
    pcnt <= (pcnt + 1) % 12;
    pa   <= 1'b1;
    pb   <= (pcnt % 2 == 0);
    pc   <= (pcnt % 3 == 0);
    pd   <= (pcnt % 4 == 0);
  end

  // Interrupt pulses seen so far, so short pulses are not missed inside bus tasks
  always @(posedge aclk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  tcm_channel u_tcm_channel (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .prescaled_clock_a(pa), .prescaled_clock_b(pb), .prescaled_clock_c(pc),
    .prescaled_clock_d(pd), .master_interrupt(mst), .timer_input_pin(pin_in),
    .timer_output_pin(pin_out), .channel_interrupt(irq));

  tcm_pin_model u_tcm_pin_model (.aclk(aclk), .timer_input_pin(pin_in),
    .timer_output_pin(pin_out));

  // ----------------------------------------
  // Bus, compare and report tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic summarize();
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Edges from one interrupt to the next, and whether the pin moved between them
  task automatic per(output int n, output logic t);
    logic o;
    do @(posedge aclk); while (irq !== 1'b1);
    repeat (2) @(posedge aclk);
    o = pin_out;
    n = 2;
    do begin
      @(posedge aclk);
      n++;
    end while (irq !== 1'b1);
    repeat (2) @(posedge aclk);
    t = pin_out ^ o;
  endtask : per

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFF_MODE_CFG, d, r);
    chk(d, 32'h0000_0000);
    rd(OFF_COMPARE, d, r);
    chk(d, 32'h0000_0000);
    rd(OFF_OUT_CTRL, d, r);
    chk(d, 32'h0000_0000);
    wr(OFF_MODE_CFG, 32'hFFFF_FFFF);
    rd(OFF_MODE_CFG, d, r);
    chk(d, 32'h0000_D7CF);
    rd(8'h18, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(OFF_COMPARE, 32'h0000_ABCD);
    strb = 4'h1;
    wr(OFF_COMPARE, 32'h0000_0012);
    strb = 4'hF;
    rd(OFF_COMPARE, d, r);
    chk(d, 32'h0000_AB12);
    $display("test regs done");
  endtask : t_regs

  task automatic t_period();
    int   n;
    logic t;
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CONTROL, 32'h0000_0002);
      wr(OFF_OUT_CTRL, 32'h0000_0001);
      wr(OFF_COMPARE, 32'h0000_0003);
      wr(OFF_MODE_CFG, 32'(s) << 14);
      wr(OFF_CONTROL, 32'h0000_0001);
      per(n, t);
      chk(32'(n), 32'(4 * div[s]));
      chk(32'(t), 32'h0000_0001);
    end
    $display("test period done");
  endtask : t_period

  task automatic t_swout();
    int          n;
    logic        t;
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CONTROL, 32'h0000_0002);
    wr(OFF_OUT_CTRL, 32'h0000_0000);
    wr(OFF_OUT_CTRL, 32'h0000_0002);
    wr(OFF_MODE_CFG, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_0001);
    per(n, t);
    chk(32'(t), 32'h0000_0000);
    chk(32'(pin_out), 32'h0000_0001);
    wr(OFF_CONTROL, 32'h0000_0002);
    wr(OFF_OUT_CTRL, 32'h0000_0001);
    wr(OFF_OUT_CTRL, 32'h0000_0003);
    rd(OFF_OUT_CTRL, d, r);
    chk(d, 32'h0000_0001);
    $display("test swout done");
  endtask : t_swout

  task automatic t_start();
    int c0;
    for (int o = 0; o < 2; o++) begin
      wr(OFF_CONTROL, 32'h0000_0002);
      wr(OFF_COMPARE, 32'h0000_0014);
      wr(OFF_MODE_CFG, 32'(o));
      c0 = irq_cnt;
      wr(OFF_CONTROL, 32'h0000_0001);
      repeat (4) @(posedge aclk);
      chk(32'(irq_cnt - c0), 32'(o));
    end
    $display("test start done");
  endtask : t_start

  task automatic trg(input logic [31:0] cfg, input bit m, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_MODE_CFG, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_0002);
    u_tcm_pin_model.drive(1'b0);
    wr(OFF_COMPARE, 32'h0000_0100);
    wr(OFF_MODE_CFG, cfg);
    if (m) begin
      mst <= 1'b1;
      @(posedge aclk);
      mst <= 1'b0;
    end else begin
      u_tcm_pin_model.drive(1'b1);
    end
    repeat (6) @(posedge aclk);
    rd(OFF_STATUS, d, r);
    chk(32'(d[0]), 32'(e));
  endtask : trg

  task automatic t_event();
    logic [31:0] d, d2;
    logic [1:0]  r;
    trg(32'h0000_1046, 1'b1, 1'b0);
    wr(OFF_COMPARE, 32'h0000_0005);
    wr(OFF_CONTROL, 32'h0000_0001);
    u_tcm_pin_model.drive(1'b0);
    repeat (6) @(posedge aclk);
    u_tcm_pin_model.drive(1'b1);
    repeat (6) @(posedge aclk);
    rd(OFF_STATUS, d, r);
    chk(32'(d[31:16]), 32'h0000_0004);
    wr(OFF_CONTROL, 32'h0000_0002);
    wr(OFF_MODE_CFG, 32'h0000_0004);
    wr(OFF_CONTROL, 32'h0000_0001);
    rd(OFF_STATUS, d, r);
    rd(OFF_STATUS, d2, r);
    chk(32'(d2[31:16] > d[31:16]), 32'h0000_0001);
    $display("test event done");
  endtask : t_event

  // One-count on the third prescaled clock, with a software retrigger while counting
  task automatic t_onecount();
    int          c0;
    logic [31:0] d;
    logic [1:0]  r;
    for (int o = 0; o < 2; o++) begin
      wr(OFF_CONTROL, 32'h0000_0002);
      wr(OFF_OUT_CTRL, 32'h0000_0001);
      wr(OFF_COMPARE, 32'h0000_0008);
      wr(OFF_MODE_CFG, 32'h0000_4008 | 32'(o));
      c0 = irq_cnt;
      wr(OFF_CONTROL, 32'h0000_0001);
      chk(32'(pin_out), 32'h0000_0001);
      wr(OFF_CONTROL, 32'h0000_0001);
      repeat (40) @(posedge aclk);
      rd(OFF_STATUS, d, r);
      chk(32'(d[0]), 32'h0000_0000);
      chk(32'(irq_cnt - c0), 32'(1 + o));
      chk(32'(pin_out), 32'h0000_0000);
    end
    $display("test onecount done");
  endtask : t_onecount

  // High-width measurement: rise starts, fall captures, then the channel stops
  task automatic t_capone();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_CONTROL, 32'h0000_0002);
    u_tcm_pin_model.drive(1'b0);
    wr(OFF_MODE_CFG, 32'h0000_02CC);
    u_tcm_pin_model.drive(1'b1);
    repeat (10) @(posedge aclk);
    u_tcm_pin_model.drive(1'b0);
    repeat (6) @(posedge aclk);
    rd(OFF_CAPTURE, d, r);
    chk(d, 32'h0000_000A);
    rd(OFF_STATUS, d, r);
    chk(32'(d[0]), 32'h0000_0000);
    $display("test capone done");
  endtask : t_capone

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_period();
    t_swout();
    t_start();
    trg(32'h0000_0040, 1'b0, 1'b0);
    trg(32'h0000_0040, 1'b1, 1'b0);
    trg(32'h0000_0140, 1'b0, 1'b1);
    trg(32'h0000_0100, 1'b0, 1'b0);
    trg(32'h0000_02C0, 1'b0, 1'b1);
    trg(32'h0000_0280, 1'b0, 1'b0);
    trg(32'h0000_0400, 1'b1, 1'b1);
    $display("test trigger done");
    t_event();
    t_onecount();
    t_capone();
    summarize();
  end
endmodule : tb
